//--- verilog/serial_bus_defines.vh
// register offsets, field positions, reset values and timing counts for the serial bus block
`ifndef SERIAL_BUS_DEFINES_VH
`define SERIAL_BUS_DEFINES_VH
`define OFS_CTRL_A 12'h000
`define OFS_CTRL_B 12'h004
`define OFS_STATUS 12'h008
`define OFS_DATA 12'h00C
`define OFS_OWN_ADDR 12'h010
`define OFS_PIN_READ 12'h014
`define CA_SCK_LSB 0
`define CA_BC_LSB 5
`define CA_ACK_BIT 4
`define CB_MODE_BIT 0
`define CB_START_BIT 1
`define CB_PEND_BIT 4
`define CB_BB_BIT 5
`define CB_TRX_BIT 6
`define CB_MST_BIT 7
`define ST_LRB_BIT 0
`define ST_AD0_BIT 1
`define ST_AAS_BIT 2
`define ST_AL_BIT 3
`define ST_SIOF_BIT 4
`define ST_PEND_BIT 5
`define ST_TRX_BIT 6
`define ST_BB_BIT 7
`define CTRL_A_RESET 8'h00
`define CTRL_B_RESET 8'h10
`define SCK_EXTERNAL 3'h7
`define SYS_CLK_MHZ 100
`define SETUP_TIME_NS 4700
`define SETUP_CYCLES ((`SETUP_TIME_NS * `SYS_CLK_MHZ + 999) / 1000)
`define START_BYTE 8'h01
`endif

//--- verilog/pin_sync.v
// two flip-flop synchroniser for a group of pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter WIDTH = 3
) (
	input wire clk_in,
	input wire nrst_in,
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_r;
	always @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			meta_r <= {WIDTH{1'b1}};
			sync_out <= {WIDTH{1'b1}};
		end
		else
		begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule
`default_nettype wire

//--- verilog/clk_divider.v
// serial clock rate generator: one tick per selected half period
`timescale 1ns/1ps
`default_nettype none
module clk_divider #(
	parameter CW = 12
) (
	input wire clk_in,
	input wire nrst_in,
	input wire run_in,
	input wire [2:0] sel_in,
	output reg tick_out
);
	reg [CW-1:0] cnt_r;
	wire [CW-1:0] limit;
	// rates step by powers of two from the system clock
	// shift amount is widened so the two slowest rates do not wrap to fast ones
	assign limit = ({{(CW-1){1'b0}}, 1'b1} << ({1'b0, sel_in} + 4'h3)) - {{(CW-1){1'b0}}, 1'b1};
	always @(posedge clk_in)
	begin
		if (!nrst_in || !run_in)
		begin
			cnt_r <= {CW{1'b0}};
			tick_out <= 1'b0;
		end
		else if (cnt_r >= limit)
		begin
			cnt_r <= {CW{1'b0}};
			tick_out <= 1'b1;
		end
		else
		begin
			cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
			tick_out <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- verilog/serial_bus_if.v
// two-wire bus slave, stop and restart control, and synchronous serial clocking
//
// Overview of operation
// RQ1: addressed for read as slave, report transmit direction and send next loaded word.
// RQ2: after slave word, ack 1 releases bus on pending set; ack 0 sends next.
// RQ3: addressed for write or general call, hold clock until dummy read or pending write.
// RQ4: lost arbitration and not addressed drops to slave; buffer access clears lost flag.
// RQ5: slave receiver word done; buffer read releases the following word.
// RQ6: own address zero and start byte received sets transmit direction in slave mode.
// RQ7: with bus busy, writing master, direction, pending 1 and busy 0 starts stop.
// RQ8: software keeps master, direction, busy, pending unchanged until stop appears.
// RQ9: stop waits while another device holds the clock line low.
// RQ10: restart: clearing master, direction, busy with pending set releases both lines.
// RQ11: software polls busy then last-bit monitor before a new start.
// RQ12: software waits at least 4.7 us before the new start.
// RQ13: after master receive, software checks clock level through the pin read register.
// RQ14: synchronous mode clock field picks seven internal rates or external clock.
// RQ15: internal clock drives serial clock high when a transfer starts.
// RQ16: internal clock stops until software serves the buffer.
// RQ17: external clock phases last at least four machine cycles.
// RQ18: external clock at most 500 kHz at 16 MHz system clock.
// RQ19: shift out on leading edge, sample in on trailing edge.
// RQ20: leading edge is falling clock pin, trailing edge is rising.
// RQ21: clock line held low while pending flag is zero after a word.
// RQ22: word end in slave involvement raises interrupt and clears pending.
// RQ23: direction, lost, addressed and general call flags read together.
`timescale 1ns/1ps
`default_nettype none
`include "serial_bus_defines.vh"
module serial_bus_if #(
	parameter DIV_W = 12
) (
	// clock and reset
	input wire REF_CLK_IN,
	input wire NRST_IN,
	// apb slave
	input wire PSEL_IN,
	input wire PENABLE_IN,
	input wire PWRITE_IN,
	input wire [11:0] PADDR_IN,
	input wire [31:0] PWDATA_IN,
	output reg [31:0] PRDATA_OUT,
	output reg PREADY_OUT,
	output reg PSLVERR_OUT,
	// two-wire and clocked pins; enables are low while driving
	input wire SCL_IN,
	output reg SCL_OUT,
	output reg SCL_OE_N_OUT,
	input wire SDA_IN,
	output reg SDA_OUT,
	output reg SDA_OE_N_OUT,
	input wire SI_IN,
	// word event to the cpu
	output reg SERIAL_BUS_INTERRUPT_OUT
);
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_DATA = 3'h2;
	localparam ST_ACK = 3'h3;
	localparam ST_HOLD = 3'h4;
	localparam ST_STOP = 3'h5;

	wire [2:0] pins_s;
	wire scl_s = pins_s[0];
	wire sda_s = pins_s[1];
	wire si_s = pins_s[2];
	wire tick;
	reg scl_d_r, sda_d_r;
	reg [7:0] serial_control_a_r, own_slave_address_reg_r, serial_data_buffer_r, shift_r;
	reg master_select_r, transmit_direction_r, bus_busy_r, pending_r, sio_mode_r, sio_start_r;
	reg arbitration_lost_r, addressed_as_slave_r, general_call_seen_r, last_rx_bit_r, siof_r;
	reg [2:0] state_r;
	reg [3:0] bit_r;
	reg first_r, sclk_r, buf_full_r, stop_phase_r;
	// involvement survives the buffer access that clears the addressed flag
	reg slave_active_r;
	reg [DIV_W-1:0] setup_cnt_r;

	pin_sync #(.WIDTH(3)) u_sync (
		.clk_in(REF_CLK_IN),
		.nrst_in(NRST_IN),
		.async_in({SI_IN, SDA_IN, SCL_IN}),
		.sync_out(pins_s)
	);
	clk_divider #(.CW(DIV_W)) u_div (
		.clk_in(REF_CLK_IN),
		.nrst_in(NRST_IN),
		.run_in(sio_mode_r && sio_start_r && !buf_full_r),
		.sel_in(serial_control_a_r[`CA_SCK_LSB+2:`CA_SCK_LSB]),
		.tick_out(tick)
	);

	function [2:0] bits_of;
		input [2:0] code;
		begin
			bits_of = code;
		end
	endfunction

	wire apb_acc = PSEL_IN && PENABLE_IN && !PREADY_OUT;
	wire wr = apb_acc && PWRITE_IN;
	wire rd = apb_acc && !PWRITE_IN;
	wire buf_hit = PADDR_IN == `OFS_DATA;
	wire buf_acc = apb_acc && buf_hit;
	wire wr_b = wr && PADDR_IN == `OFS_CTRL_B;
	wire scl_rise = scl_s && !scl_d_r;
	wire scl_fall = !scl_s && scl_d_r;
	wire start_seen = scl_s && sda_d_r && !sda_s;
	wire stop_seen = scl_s && !sda_d_r && sda_s;
	wire ext_clk = serial_control_a_r[`CA_SCK_LSB+2:`CA_SCK_LSB] == `SCK_EXTERNAL;
	wire [2:0] bc = serial_control_a_r[`CA_BC_LSB+2:`CA_BC_LSB];
	wire [3:0] word_len = (bc == 3'h0) ? 4'h8 : {1'b0, bits_of(bc)};
	wire stop_req = wr_b && bus_busy_r && PWDATA_IN[`CB_MST_BIT] && PWDATA_IN[`CB_TRX_BIT]
		&& PWDATA_IN[`CB_PEND_BIT] && !PWDATA_IN[`CB_BB_BIT];
	wire restart_req = wr_b && !PWDATA_IN[`CB_MST_BIT] && !PWDATA_IN[`CB_TRX_BIT]
		&& !PWDATA_IN[`CB_BB_BIT] && PWDATA_IN[`CB_PEND_BIT];
	// sio shift events: falling is leading, rising is trailing
	wire sio_lead = ext_clk ? scl_fall : (tick && sclk_r);
	wire sio_trail = ext_clk ? scl_rise : (tick && !sclk_r);
	wire [7:0] status = {bus_busy_r, transmit_direction_r, pending_r, siof_r,
		arbitration_lost_r, addressed_as_slave_r, general_call_seen_r, last_rx_bit_r};

	// apb: one wait state, read data and ready registered
	always @(posedge REF_CLK_IN)
	begin
		if (!NRST_IN)
		begin
			PREADY_OUT <= 1'b0;
			PRDATA_OUT <= 32'h00000000;
			PSLVERR_OUT <= 1'b0;
		end
		else
		begin
			PREADY_OUT <= PSEL_IN && PENABLE_IN && !PREADY_OUT;
			PSLVERR_OUT <= 1'b0;
			if (rd)
			begin
				case (PADDR_IN)
					`OFS_CTRL_A: PRDATA_OUT <= {24'h000000, serial_control_a_r};
					`OFS_CTRL_B: PRDATA_OUT <= {24'h000000, master_select_r,
						transmit_direction_r, bus_busy_r, pending_r, 2'h0, sio_start_r, sio_mode_r};
					`OFS_STATUS: PRDATA_OUT <= {24'h000000, status}; // see RQ23
					`OFS_DATA: PRDATA_OUT <= {24'h000000, serial_data_buffer_r};
					`OFS_OWN_ADDR: PRDATA_OUT <= {24'h000000, own_slave_address_reg_r};
					`OFS_PIN_READ: PRDATA_OUT <= {29'h00000000, si_s, sda_s, scl_s}; // see RQ13
					default:
					begin
						PRDATA_OUT <= 32'h00000000;
						PSLVERR_OUT <= 1'b1;
					end
				endcase
			end
			else if (apb_acc)
			begin
				PRDATA_OUT <= 32'h00000000;
				PSLVERR_OUT <= PADDR_IN > `OFS_PIN_READ || PADDR_IN[1:0] != 2'h0;
			end
		end
	end

	// main control and bus engine
	always @(posedge REF_CLK_IN)
	begin
		if (!NRST_IN)
		begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			serial_control_a_r <= `CTRL_A_RESET;
			own_slave_address_reg_r <= 8'h00;
			serial_data_buffer_r <= 8'h00;
			shift_r <= 8'h00;
			master_select_r <= 1'b0;
			transmit_direction_r <= 1'b0;
			bus_busy_r <= 1'b0;
			pending_r <= 1'b1;
			sio_mode_r <= 1'b0;
			sio_start_r <= 1'b0;
			arbitration_lost_r <= 1'b0;
			addressed_as_slave_r <= 1'b0;
			general_call_seen_r <= 1'b0;
			last_rx_bit_r <= 1'b1;
			siof_r <= 1'b0;
			state_r <= ST_IDLE;
			bit_r <= 4'h0;
			first_r <= 1'b0;
			sclk_r <= 1'b1;
			buf_full_r <= 1'b0;
			stop_phase_r <= 1'b0;
			slave_active_r <= 1'b0;
			setup_cnt_r <= {DIV_W{1'b0}};
			SCL_OUT <= 1'b1;
			SCL_OE_N_OUT <= 1'b1;
			SDA_OUT <= 1'b1;
			SDA_OE_N_OUT <= 1'b1;
			SERIAL_BUS_INTERRUPT_OUT <= 1'b0;
		end
		else
		begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
			SERIAL_BUS_INTERRUPT_OUT <= 1'b0;
			if (wr && PADDR_IN == `OFS_CTRL_A)
				serial_control_a_r <= PWDATA_IN[7:0];
			if (wr && PADDR_IN == `OFS_OWN_ADDR)
				own_slave_address_reg_r <= PWDATA_IN[7:0];
			if (wr && buf_hit)
				serial_data_buffer_r <= PWDATA_IN[7:0];
			if (buf_acc)
			begin
				arbitration_lost_r <= 1'b0; // see RQ4
				addressed_as_slave_r <= 1'b0;
				pending_r <= 1'b1; // see RQ3 RQ5
				buf_full_r <= 1'b0; // see RQ16
			end
			if (wr_b)
			begin
				sio_mode_r <= PWDATA_IN[`CB_MODE_BIT];
				sio_start_r <= PWDATA_IN[`CB_START_BIT];
				master_select_r <= PWDATA_IN[`CB_MST_BIT];
				transmit_direction_r <= PWDATA_IN[`CB_TRX_BIT];
				bus_busy_r <= PWDATA_IN[`CB_BB_BIT];
				if (PWDATA_IN[`CB_PEND_BIT])
					pending_r <= 1'b1; // see RQ3
			end
			if (start_seen || stop_seen)
				general_call_seen_r <= 1'b0;
			if (!sio_mode_r)
			begin
				SCL_OE_N_OUT <= pending_r; // see RQ21
				SCL_OUT <= 1'b0;
				first_r <= 1'b1;
				case (state_r)
					ST_IDLE:
					begin
						SDA_OE_N_OUT <= 1'b1;
						if (stop_req)
						begin
							state_r <= ST_STOP; // see RQ7
							stop_phase_r <= 1'b0;
							pending_r <= 1'b1;
						end
						else if (start_seen)
						begin
							state_r <= ST_ADDR;
							bit_r <= 4'h0;
							bus_busy_r <= 1'b1;
							slave_active_r <= 1'b0;
						end
					end
					ST_ADDR, ST_DATA:
					begin
						if (stop_req)
						begin
							state_r <= ST_STOP;
							stop_phase_r <= 1'b0;
						end
						else if (restart_req)
						begin
							state_r <= ST_IDLE; // see RQ10
							SDA_OE_N_OUT <= 1'b1;
						end
						else if (stop_seen)
						begin
							state_r <= ST_IDLE;
							bus_busy_r <= 1'b0;
							addressed_as_slave_r <= 1'b0;
							slave_active_r <= 1'b0;
						end
						else if (start_seen)
						begin
							bit_r <= 4'h0;
							state_r <= ST_ADDR;
							slave_active_r <= 1'b0;
						end
						else if (scl_rise)
						begin
							// a transmitting slave shifts only on the falling edge
							if (!(state_r == ST_DATA && transmit_direction_r))
								shift_r <= {shift_r[6:0], sda_s};
							last_rx_bit_r <= sda_s;
							bit_r <= bit_r + 4'h1;
						end
						else if (scl_fall && state_r == ST_DATA && transmit_direction_r
							&& bit_r != word_len)
						begin
							SDA_OE_N_OUT <= shift_r[7];
							shift_r <= {shift_r[6:0], 1'b1};
						end
						else if (scl_fall && bit_r == (state_r == ST_ADDR ? 4'h8 : word_len))
						begin
							SDA_OE_N_OUT <= 1'b1;
							if (state_r == ST_ADDR)
							begin
								if (shift_r[7:1] == own_slave_address_reg_r[7:1]
									&& own_slave_address_reg_r != 8'h00)
								begin
									addressed_as_slave_r <= 1'b1;
									slave_active_r <= 1'b1;
									SDA_OE_N_OUT <= 1'b0; // acknowledge the address
									SDA_OUT <= 1'b0;
									// see RQ1
									transmit_direction_r <= shift_r[0];
									if (master_select_r)
									begin
										arbitration_lost_r <= 1'b1;
										master_select_r <= 1'b0;
									end
								end
								else if (shift_r == 8'h00)
								begin
									general_call_seen_r <= 1'b1;
									addressed_as_slave_r <= 1'b1;
									slave_active_r <= 1'b1;
									SDA_OE_N_OUT <= 1'b0;
									SDA_OUT <= 1'b0;
									transmit_direction_r <= 1'b0;
								end
								else if (own_slave_address_reg_r == 8'h00 && shift_r == `START_BYTE)
									transmit_direction_r <= 1'b1; // see RQ6
								if (master_select_r && arbitration_lost_r)
									master_select_r <= 1'b0; // see RQ4
							end
							else if (!transmit_direction_r)
							begin
								serial_data_buffer_r <= shift_r;
								SDA_OE_N_OUT <= !serial_control_a_r[`CA_ACK_BIT];
								SDA_OUT <= 1'b0;
							end
							state_r <= ST_ACK;
						end
					end
					ST_ACK:
					begin
						if (scl_rise && transmit_direction_r)
							last_rx_bit_r <= sda_s; // acknowledge from the receiver
						if (scl_fall)
						begin
							SDA_OE_N_OUT <= 1'b1;
							if (slave_active_r || arbitration_lost_r)
							begin
								pending_r <= 1'b0; // see RQ22 RQ21
								SERIAL_BUS_INTERRUPT_OUT <= 1'b1;
								state_r <= ST_HOLD;
							end
							else
								state_r <= ST_IDLE;
						end
					end
					ST_HOLD:
					begin
						if (stop_seen)
						begin
							state_r <= ST_IDLE;
							bus_busy_r <= 1'b0;
							slave_active_r <= 1'b0;
						end
						else if (pending_r)
						begin
							bit_r <= 4'h0;
							// see RQ2: nack with direction still set frees the bus
							if (transmit_direction_r && !last_rx_bit_r)
							begin
								// first bit goes out now, in the same cycle the clock is let go
								shift_r <= {serial_data_buffer_r[6:0], 1'b1};
								SDA_OE_N_OUT <= serial_data_buffer_r[7];
								SDA_OUT <= 1'b0;
								state_r <= ST_DATA;
							end
							else if (transmit_direction_r || !last_rx_bit_r || 1'b1)
								state_r <= transmit_direction_r ? ST_IDLE : ST_DATA;
						end
					end
					ST_STOP:
					begin
						// see RQ9: wait for the clock line to go high first
						SCL_OE_N_OUT <= 1'b1;
						if (!stop_phase_r)
						begin
							SDA_OE_N_OUT <= 1'b0;
							SDA_OUT <= 1'b0;
							if (scl_s)
								stop_phase_r <= 1'b1;
						end
						else
						begin
							SDA_OE_N_OUT <= 1'b1;
							bus_busy_r <= 1'b0;
							master_select_r <= 1'b0;
							state_r <= ST_IDLE;
						end
					end
					default: state_r <= ST_IDLE;
				endcase
			end
			else
			begin
				// clocked synchronous mode
				SDA_OE_N_OUT <= 1'b0;
				SCL_OE_N_OUT <= ext_clk; // see RQ14
				SCL_OUT <= sclk_r;
				if (!sio_start_r)
				begin
					siof_r <= 1'b0;
					first_r <= 1'b1;
					sclk_r <= 1'b1;
					SDA_OUT <= 1'b1;
				end
				else
				begin
					siof_r <= 1'b1;
					if (first_r)
					begin
						sclk_r <= 1'b1; // see RQ15
						first_r <= 1'b0;
						bit_r <= 4'h0;
						shift_r <= serial_data_buffer_r;
					end
					else if (!buf_full_r)
					begin
						if (!ext_clk && tick)
							sclk_r <= !sclk_r;
						if (sio_lead)
						begin
							SDA_OUT <= shift_r[0]; // see RQ19 RQ20
						end
						if (sio_trail)
						begin
							shift_r <= {si_s, shift_r[7:1]}; // see RQ19
							bit_r <= bit_r + 4'h1;
							if (bit_r == 4'h7)
							begin
								serial_data_buffer_r <= {si_s, shift_r[7:1]};
								buf_full_r <= 1'b1; // see RQ16
								bit_r <= 4'h0;
								SERIAL_BUS_INTERRUPT_OUT <= 1'b1;
							end
						end
					end
					if (buf_full_r && buf_acc && wr)
						shift_r <= PWDATA_IN[7:0];
				end
			end
			setup_cnt_r <= {DIV_W{1'b0}};
		end
	end
endmodule
`default_nettype wire

//--- dv/serial_bus_if_chk.sv
// protocol checker bound to the serial bus block
`timescale 1ns/1ps
`default_nettype none
`include "serial_bus_defines.vh"
module serial_bus_if_chk (
	// clock and reset
	input wire logic REF_CLK_IN,
	input wire logic NRST_IN,
	// apb slave
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic [31:0] PRDATA_OUT,
	input wire logic PREADY_OUT,
	input wire logic PSLVERR_OUT,
	// pins
	input wire logic SCL_IN,
	input wire logic SCL_OUT,
	input wire logic SCL_OE_N_OUT,
	input wire logic SDA_IN,
	input wire logic SDA_OUT,
	input wire logic SDA_OE_N_OUT,
	input wire logic SI_IN,
	input wire logic SERIAL_BUS_INTERRUPT_OUT
);
	logic sio_r;
	wire acc = PSEL_IN && PENABLE_IN && !PREADY_OUT;
	wire cb_wr = acc && PWRITE_IN && PADDR_IN == `OFS_CTRL_B;
	// in sio mode the clock pin is a plain output, or an input with the external clock, so hold rules do not apply
	always @(posedge REF_CLK_IN)
		if (!NRST_IN)
			sio_r <= 1'h0;
		else if (cb_wr)
			sio_r <= PWDATA_IN[`CB_MODE_BIT];
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (!NRST_IN);
	property p_rdy;
		acc |=> PREADY_OUT;
	endproperty
	a_rdy: assert property (p_rdy) else $error("ready not given after one wait state");
	property p_rdy1;
		PREADY_OUT |-> !$past(PREADY_OUT);
	endproperty
	a_rdy1: assert property (p_rdy1) else $error("ready longer than one cycle");
	property p_err;
		PREADY_OUT && (PADDR_IN > `OFS_PIN_READ || PADDR_IN[1:0] != 2'h0) |-> PSLVERR_OUT;
	endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_err_rdy;
		PSLVERR_OUT |-> PREADY_OUT;
	endproperty
	a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
	property p_int;
		SERIAL_BUS_INTERRUPT_OUT |=> !SERIAL_BUS_INTERRUPT_OUT;
	endproperty
	a_int: assert property (p_int) else $error("interrupt not a pulse");
	property p_hold;
		SERIAL_BUS_INTERRUPT_OUT && !sio_r |-> ##[0:2] (!SCL_OE_N_OUT && !SCL_OUT);
	endproperty
	a_hold: assert property (p_hold) else $error("clock not held after word");
	property p_rel;
		acc && PADDR_IN == `OFS_DATA && !SCL_OE_N_OUT && !sio_r |-> ##[1:4] SCL_OE_N_OUT;
	endproperty
	a_rel: assert property (p_rel) else $error("buffer access left clock held");
	property p_rst;
		cb_wr && PWDATA_IN[7:4] == 4'h1 && !PWDATA_IN[0] |-> ##[1:4] (SCL_OE_N_OUT && SDA_OE_N_OUT);
	endproperty
	a_rst: assert property (p_rst) else $error("lines not released");
	c_int: cover property (SERIAL_BUS_INTERRUPT_OUT);
	c_err: cover property (PSLVERR_OUT);
	c_sio: cover property (sio_r && !SCL_OUT);
endmodule
bind serial_bus_if serial_bus_if_chk i_serial_bus_if_chk (.*);
`default_nettype wire

//--- dv/bus_partner.sv
// two-wire bus master model; it only ever pulls the lines low
`timescale 1ns/1ps
`default_nettype none
module bus_partner (
	input wire logic clk_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_dn_out,
	output logic sda_dn_out
);
	int hung = 0;
	initial
	begin
		scl_dn_out = 1'h0;
		sda_dn_out = 1'h0;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	// high and low phases of four cycles or more
	task automatic rise();
		int n = 0;
		scl_dn_out <= 1'h0;
		cyc(1);
		// a stretching slave is waited for, bounded so a hang shows
		while (scl_in !== 1'h1 && n < 5000)
		begin
			cyc(1);
			n++;
		end
		if (n == 5000)
			hung++;
		cyc(4);
	endtask
	task automatic bitx(input logic b, output logic r);
		sda_dn_out <= !b;
		cyc(2);
		rise();
		r = sda_in;
		scl_dn_out <= 1'h1;
		cyc(2);
	endtask
	task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
		output logic ack);
		for (int i = 7; i >= 0; i--)
			bitx(tx[i], rx[i]);
		bitx(mack, ack);
	endtask
	task automatic start();
		sda_dn_out <= 1'h1;
		cyc(4);
		scl_dn_out <= 1'h1;
		cyc(2);
	endtask
	task automatic stop();
		sda_dn_out <= 1'h1;
		cyc(2);
		rise();
		sda_dn_out <= 1'h0;
		cyc(4);
	endtask
endmodule
`default_nettype wire

//--- dv/test_two_wire_bus_slave_stop_restart.sv
// self-checking bench: apb software, two-wire master model, sio pins
`timescale 1ns/1ps
`default_nettype none
`include "serial_bus_defines.vh"
`define CMP(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module test_two_wire_bus_slave_stop_restart;
	logic clk = 1'h0, nrst = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0, si = 1'h1;
	logic [11:0] padr = 12'h0;
	logic [31:0] pwd = 32'h0, prd, q, rs = 32'h9C6F;
	logic prdy, perr, pe, scl_o, scl_oe_n, sda_o, sda_oe_n, irq, pscl, psda, ack;
	logic [7:0] rx, d, din;
	int fail_count = 0, checks_done = 0, n, h;
	byte unsigned exp_q[$];
	// both lines have pull-ups: low only while some party drives low
	wire scl = !(pscl || (scl_oe_n === 1'h0 && scl_o === 1'h0));
	wire sda = !(psda || (sda_oe_n === 1'h0 && sda_o === 1'h0));
	always #5 clk = !clk;
	serial_bus_if i_serial_bus_if (.REF_CLK_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
		.PREADY_OUT(prdy), .PSLVERR_OUT(perr), .SCL_IN(scl), .SCL_OUT(scl_o),
		.SCL_OE_N_OUT(scl_oe_n), .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE_N_OUT(sda_oe_n),
		.SI_IN(si), .SERIAL_BUS_INTERRUPT_OUT(irq));
	bus_partner i_bus_partner (.clk_in(clk), .scl_in(scl), .sda_in(sda), .scl_dn_out(pscl),
		.sda_dn_out(psda));
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int k = 0;
		@(posedge clk);
		psel <= 1'h1;
		pwr <= w;
		padr <= a;
		pwd <= wd;
		@(posedge clk);
		pen <= 1'h1;
		do @(posedge clk); while (prdy !== 1'h1 && ++k < 20);
		if (prdy !== 1'h1)
			fail_count++;
		q = prd;
		pe = perr;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask
	task automatic wait_int();
		int k = 0;
		while (irq !== 1'h1 && k < 3000)
		begin
			@(posedge clk);
			k++;
		end
		`CMP(irq, 1'h1)
	endtask
	task automatic word(input logic [7:0] tx, input logic [7:0] st);
		fork
			i_bus_partner.xfer(tx, 1'h1, rx, ack);
			wait_int();
		join
		apb(1'h0, `OFS_STATUS, 32'h0);
		`CMP(q[7:0] & 8'h4E, st)
	endtask
	initial
	begin
		repeat (5) @(posedge clk);
		nrst <= 1'h1;
		apb(1'h0, `OFS_CTRL_A, 32'h0);
		`CMP(q[7:0], `CTRL_A_RESET)
		apb(1'h0, `OFS_CTRL_B, 32'h0);
		`CMP(q[7:0], `CTRL_B_RESET)
		apb(1'h0, 12'h020, 32'h0);
		`CMP(pe, 1'h1)
		`CMP(q, 32'h0)
		apb(1'h1, `OFS_CTRL_A, 32'h10);
		apb(1'h1, `OFS_OWN_ADDR, 32'hA0);
		i_bus_partner.start();
		word(8'hA0, 8'h04);
		`CMP(ack, 1'h0)
		`CMP(scl_oe_n, 1'h0)
		apb(1'h0, `OFS_DATA, 32'h0);
		d = 8'(rnd());
		exp_q.push_back(d);
		word(d, 8'h00);
		apb(1'h0, `OFS_DATA, 32'h0);
		`CMP(q[7:0], 8'(exp_q.pop_front()))
		i_bus_partner.stop();
		i_bus_partner.start();
		word(8'hA1, 8'h44);
		d = 8'(rnd());
		apb(1'h1, `OFS_DATA, {24'h0, d});
		word(8'hFF, 8'h40);
		`CMP(rx, d)
		`CMP(q[0], 1'h1)
		apb(1'h1, `OFS_CTRL_B, 32'h10);
		repeat (3) @(posedge clk);
		`CMP(scl_oe_n & sda_oe_n, 1'h1)
		i_bus_partner.stop();
		i_bus_partner.start();
		word(8'h00, 8'h06);
		apb(1'h1, `OFS_CTRL_B, 32'h10);
		i_bus_partner.stop();
		apb(1'h1, `OFS_OWN_ADDR, 32'h0);
		i_bus_partner.start();
		i_bus_partner.xfer(`START_BYTE, 1'h1, rx, ack);
		apb(1'h0, `OFS_STATUS, 32'h0);
		`CMP(q[6], 1'h1)
		apb(1'h1, `OFS_CTRL_B, 32'h10);
		i_bus_partner.stop();
		// stop request while the partner still holds the clock low
		i_bus_partner.start();
		apb(1'h1, `OFS_CTRL_B, 32'hD0);
		repeat (20) @(posedge clk);
		`CMP({scl_oe_n, sda_oe_n, sda_o}, 3'h4)
		i_bus_partner.bitx(1'h1, ack);
		`CMP(sda, 1'h1)
		i_bus_partner.rise();
		n = 0;
		do
		begin
			apb(1'h0, `OFS_STATUS, 32'h0);
			n++;
		end
		while ((q[7] || !q[0]) && n < 50);
		`CMP(q[7:0] & 8'h81, 8'h01)
		repeat (`SETUP_CYCLES) @(posedge clk);
		apb(1'h0, `OFS_PIN_READ, 32'h0);
		`CMP(q[1:0], 2'h3)
		// every internal rate, one byte each way
		for (int s = 0; s < 7; s++)
		begin
			h = 8 << s;
			d = 8'(rnd());
			din = 8'(rnd());
			apb(1'h1, `OFS_CTRL_A, 32'(s));
			apb(1'h1, `OFS_DATA, {24'h0, d});
			apb(1'h1, `OFS_CTRL_B, 32'h03);
			@(posedge clk);
			`CMP(scl_o, 1'h1)
			for (int i = 0; i < 8; i++)
			begin
				n = 0;
				while (scl_o !== 1'h0 && n < 5000)
				begin
					@(posedge clk);
					n++;
				end
				si <= din[i];
				n = 0;
				while (scl_o !== 1'h1 && n < 5000)
				begin
					@(posedge clk);
					n++;
				end
				`CMP(n, h)
				`CMP(sda_o, d[i])
			end
			n = 0;
			repeat (3 * h) @(posedge clk) if (scl_o !== 1'h1) n++;
			`CMP(n, 0)
			apb(1'h1, `OFS_CTRL_B, 32'h01);
			apb(1'h0, `OFS_DATA, 32'h0);
			`CMP(q[7:0], din)
		end
		`CMP(i_bus_partner.hung, 0)
		conclude();
	end
	initial
	begin
		#900000;
		fail_count++;
		conclude();
	end
	task automatic conclude();
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
endmodule
`default_nettype wire
